// ### apb_front.sv
// APB handshake: one wait state, then the answer with pready.
`timescale 1ns/10ps
module apb_front (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic mapped,
	output logic capture,
	output logic commit,
	output logic pready_ff,
	output logic pslverr_ff
);
	// The first access cycle captures read data; the second completes.
	assign capture = psel && penable && !pready_ff;
	assign commit = psel && penable && pready_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
		end else begin
			pready_ff <= capture;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_ff <= 1'b0;
		end else begin
			pslverr_ff <= capture && !mapped;
		end
	end
endmodule

// ### codec_enable_input_select_regs.sv
// Codec enable and microphone input routing registers behind an APB slave.
`timescale 1ns/10ps
module codec_enable_input_select_regs (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [codec_regs_pkg::ADDR_W-1:0] paddr,
	input wire logic [codec_regs_pkg::DATA_W-1:0] pwdata,
	output logic [codec_regs_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic codec_master_enable,
	output logic codec_sysclock_enable,
	output logic analog_bias_enable,
	output logic left_preamp_enable,
	output logic right_preamp_enable,
	output logic left_pos1_connect,
	output logic left_neg_connect,
	output logic left_pos2_connect,
	output logic right_pos1_connect,
	output logic right_neg_connect,
	output logic right_pos2_connect
);
	import codec_regs_pkg::*;

	logic [IDX_W-1:0] idx;
	logic mapped;
	logic capture;
	logic commit;
	logic wr_en;
	logic [NUM_BITS-1:0] bit_q;
	logic [DATA_W-1:0] rd_word;
	logic [DATA_W-1:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;

	assign idx = paddr[IDX_W+1:2];

	// Only word-aligned accesses to the seven registers are mapped.
	always_comb begin
		mapped = 1'b0;
		if (paddr[1:0] == 2'h0 && paddr[ADDR_W-1:IDX_W+2] == '0) begin
			unique case (idx)
				IDX_POWER_MGMT_ONE,
				IDX_POWER_MGMT_TWO,
				IDX_POWER_MGMT_FOUR,
				IDX_POWER_MGMT_FIVE,
				IDX_MIC_INPUT_ROUTING,
				IDX_LEFT_INPUT_VOLUME,
				IDX_RIGHT_INPUT_VOLUME: mapped = 1'b1;
				default: mapped = 1'b0;
			endcase
		end
	end

	apb_front u_apb_front (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.mapped(mapped),
		.capture(capture),
		.commit(commit),
		.pready_ff(pready_ff),
		.pslverr_ff(pslverr_ff)
	);

	// Writes land only at the completing edge of a mapped access.
	assign wr_en = commit && pwrite && mapped;

	// Every bit but the master enable is held while the master is clear.
	for (genvar i = 0; i < NUM_BITS; i++) begin : g_bit
		ctrl_bit #(
			.RST_VAL(BIT_RESET[i])
		) u_bit (
			.clk(pclk),
			.rst_n(presetn),
			.hold((i != 0) && !bit_q[0]),
			.wr_a(wr_en && idx == BIT_IDX_A[i]),
			.d_a(pwdata[BIT_POS_A[i]]),
			.wr_b(wr_en && idx == BIT_IDX_B[i]),
			.d_b(pwdata[BIT_POS_B[i]]),
			.q_ff(bit_q[i])
		);
	end

	// Both locations of an aliased bit read the same storage.
	always_comb begin
		rd_word = '0;
		for (int i = 0; i < NUM_BITS; i++) begin
			if (idx == BIT_IDX_A[i]) begin
				rd_word[BIT_POS_A[i]] = bit_q[i];
			end
			if (idx == BIT_IDX_B[i]) begin
				rd_word[BIT_POS_B[i]] = bit_q[i];
			end
		end
	end

	// Read data is caught in the first access cycle and held.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= '0;
		end else if (capture) begin
			prdata_ff <= (mapped && !pwrite) ? rd_word : '0;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

	// Enables and pin connections come straight from the storage bits.
	assign codec_master_enable = bit_q[0];
	assign codec_sysclock_enable = bit_q[1];
	assign analog_bias_enable = bit_q[2];
	assign left_preamp_enable = bit_q[3];
	assign right_preamp_enable = bit_q[4];
	assign left_pos1_connect = bit_q[5];
	assign left_neg_connect = bit_q[6];
	assign left_pos2_connect = bit_q[7];
	assign right_pos1_connect = bit_q[8];
	assign right_neg_connect = bit_q[9];
	assign right_pos2_connect = bit_q[10];

	// Checks on the register behaviour.
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic wr_live;
	assign wr_live = wr_en && codec_master_enable;

	property p_hold_reset;
		!codec_master_enable |=>
			!codec_sysclock_enable && !analog_bias_enable &&
			!left_preamp_enable && !right_preamp_enable &&
			left_pos1_connect && left_neg_connect && !left_pos2_connect &&
			right_pos1_connect && right_neg_connect && !right_pos2_connect;
	endproperty
	a_hold_reset: assert property (p_hold_reset)
		else $error("held bit left its reset value");

	property p_master_write;
		wr_en && idx == IDX_POWER_MGMT_FIVE |=>
			codec_master_enable == $past(pwdata[POS_MASTER]);
	endproperty
	a_master_write: assert property (p_master_write)
		else $error("master enable did not take write");

	property p_bias_write;
		wr_live && idx == IDX_POWER_MGMT_ONE |=>
			analog_bias_enable == $past(pwdata[POS_BIAS]);
	endproperty
	a_bias_write: assert property (p_bias_write)
		else $error("bias enable did not take write");

	property p_bias_read;
		capture && mapped && !pwrite &&
			idx == IDX_POWER_MGMT_ONE |=>
			prdata[POS_BIAS] == $past(analog_bias_enable);
	endproperty
	a_bias_read: assert property (p_bias_read)
		else $error("bias enable read back wrong");

	property p_stay_off;
		!codec_master_enable ##1 !codec_master_enable |->
			!left_preamp_enable && !right_preamp_enable;
	endproperty
	a_stay_off: assert property (p_stay_off)
		else $error("preamp active without master enable");

	property p_left_alias;
		wr_live && idx == IDX_LEFT_INPUT_VOLUME |=>
			left_preamp_enable == $past(pwdata[POS_VOL_PREAMP]);
	endproperty
	a_left_alias: assert property (p_left_alias)
		else $error("left preamp alias write lost");

	property p_left_home;
		wr_live && idx == IDX_POWER_MGMT_TWO |=>
			left_preamp_enable == $past(pwdata[POS_LEFT_PREAMP]);
	endproperty
	a_left_home: assert property (p_left_home)
		else $error("left preamp home write lost");

	property p_left_alias_read;
		capture && mapped && !pwrite &&
			idx == IDX_LEFT_INPUT_VOLUME |=>
			prdata == {16'h0000, $past(left_preamp_enable), 15'h0000};
	endproperty
	a_left_alias_read: assert property (p_left_alias_read)
		else $error("left volume word read wrong");

	property p_right_alias;
		wr_live && idx == IDX_RIGHT_INPUT_VOLUME |=>
			right_preamp_enable == $past(pwdata[POS_VOL_PREAMP]);
	endproperty
	a_right_alias: assert property (p_right_alias)
		else $error("right preamp alias write lost");

	property p_pm2_read;
		capture && mapped && !pwrite &&
			idx == IDX_POWER_MGMT_TWO |=>
			prdata == {22'h000000, $past(right_preamp_enable),
			$past(left_preamp_enable), 8'h00};
	endproperty
	a_pm2_read: assert property (p_pm2_read)
		else $error("power_mgmt_two read wrong");

	property p_left_route;
		wr_live && idx == IDX_MIC_INPUT_ROUTING |=>
			{left_pos2_connect, left_neg_connect, left_pos1_connect} ==
			$past(pwdata[2:0]);
	endproperty
	a_left_route: assert property (p_left_route)
		else $error("left routing did not take write");

	property p_right_route;
		wr_live && idx == IDX_MIC_INPUT_ROUTING |=>
			{right_pos2_connect, right_neg_connect, right_pos1_connect} ==
			$past(pwdata[10:8]);
	endproperty
	a_right_route: assert property (p_right_route)
		else $error("right routing did not take write");

	property p_route_read;
		capture && mapped && !pwrite &&
			idx == IDX_MIC_INPUT_ROUTING |=>
			prdata[31:11] == 21'h000000 && prdata[7:3] == 5'h00 &&
			prdata[1] == $past(left_neg_connect) &&
			prdata[2] == $past(left_pos2_connect);
	endproperty
	a_route_read: assert property (p_route_read)
		else $error("routing word read wrong");

	property p_route_keep;
		!(wr_live && idx == IDX_MIC_INPUT_ROUTING) && codec_master_enable
			##1 codec_master_enable |->
			$stable(left_pos2_connect) && $stable(right_pos2_connect);
	endproperty
	a_route_keep: assert property (p_route_keep)
		else $error("routing changed without a write");

	property p_unmapped;
		capture && !mapped |=> pready && pslverr && prdata == '0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped access not flagged");

	property p_sysclock_write;
		wr_live && idx == IDX_POWER_MGMT_FOUR |=>
			codec_sysclock_enable == $past(pwdata[POS_SYSCLOCK]);
	endproperty
	a_sysclock_write: assert property (p_sysclock_write)
		else $error("sysclock enable did not take write");

	property p_right_home;
		wr_live && idx == IDX_POWER_MGMT_TWO |=>
			right_preamp_enable == $past(pwdata[POS_RIGHT_PREAMP]);
	endproperty
	a_right_home: assert property (p_right_home)
		else $error("right preamp home write lost");

	property p_right_alias_read;
		capture && mapped && !pwrite &&
			idx == IDX_RIGHT_INPUT_VOLUME |=>
			prdata ==
			{16'h0000, $past(right_preamp_enable), 15'h0000};
	endproperty
	a_right_alias_read: assert property (p_right_alias_read)
		else $error("right volume word read wrong");

	property p_master_read;
		capture && mapped && !pwrite &&
			idx == IDX_POWER_MGMT_FIVE |=>
			prdata == {19'h0, $past(codec_master_enable), 12'h0};
	endproperty
	a_master_read: assert property (p_master_read)
		else $error("master enable read back wrong");

	property p_mapped_ok;
		capture && mapped |=> pready && !pslverr;
	endproperty
	a_mapped_ok: assert property (p_mapped_ok)
		else $error("mapped access flagged or late");

	property p_write_data;
		capture && pwrite |=> prdata == '0;
	endproperty
	a_write_data: assert property (p_write_data)
		else $error("read data not cleared on write");

	// An unmapped write must leave every storage bit where it was.
	property p_unmapped_keep;
		capture && !mapped ##1 codec_master_enable |=> $stable(bit_q);
	endproperty
	a_unmapped_keep: assert property (p_unmapped_keep)
		else $error("unmapped write changed a bit");

	property p_answer;
		capture |=> pready ##1 !pready;
	endproperty
	a_answer: assert property (p_answer)
		else $error("pready not a single cycle after one wait");

	c_master_on: cover property (wr_en && idx == IDX_POWER_MGMT_FIVE &&
		pwdata[POS_MASTER]);
	c_alias_write: cover property (wr_live &&
		idx == IDX_RIGHT_INPUT_VOLUME && pwdata[POS_VOL_PREAMP]);
	c_route_read: cover property (capture && !pwrite &&
		idx == IDX_MIC_INPUT_ROUTING && codec_master_enable);
	c_unmapped: cover property (capture && !mapped);
	c_master_clear: cover property (wr_en && idx == IDX_POWER_MGMT_FIVE &&
		!pwdata[POS_MASTER] && codec_master_enable);
endmodule

// ### codec_host_model.sv
// Host model that makes APB transfers to the codec register block.
`timescale 1ns/10ps
module codec_host_model (
	input wire logic pclk,
	input wire logic pready,
	input wire logic [codec_regs_pkg::DATA_W-1:0] prdata,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [codec_regs_pkg::ADDR_W-1:0] paddr,
	output logic [codec_regs_pkg::DATA_W-1:0] pwdata
);
	import codec_regs_pkg::*;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end
	// The request stands unchanged until pready is seen at a rising edge.
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] rd,
		output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// ### codec_regs_pkg.sv
// Constants for the codec enable and microphone input routing registers.
package codec_regs_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int IDX_W = 8;
	localparam int POS_W = 5;
	localparam int NUM_BITS = 11;

	// Register indices; the byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_POWER_MGMT_ONE = 8'h08;
	localparam logic [IDX_W-1:0] IDX_POWER_MGMT_TWO = 8'h09;
	localparam logic [IDX_W-1:0] IDX_POWER_MGMT_FOUR = 8'h0b;
	localparam logic [IDX_W-1:0] IDX_POWER_MGMT_FIVE = 8'h0c;
	localparam logic [IDX_W-1:0] IDX_MIC_INPUT_ROUTING = 8'h48;
	localparam logic [IDX_W-1:0] IDX_LEFT_INPUT_VOLUME = 8'h50;
	localparam logic [IDX_W-1:0] IDX_RIGHT_INPUT_VOLUME = 8'h51;

	// Field positions.
	localparam logic [POS_W-1:0] POS_MASTER = 5'h0c;
	localparam logic [POS_W-1:0] POS_SYSCLOCK = 5'h0e;
	localparam logic [POS_W-1:0] POS_BIAS = 5'h05;
	localparam logic [POS_W-1:0] POS_LEFT_PREAMP = 5'h08;
	localparam logic [POS_W-1:0] POS_RIGHT_PREAMP = 5'h09;
	localparam logic [POS_W-1:0] POS_VOL_PREAMP = 5'h0f;
	localparam logic [POS_W-1:0] POS_LEFT_POS1 = 5'h00;
	localparam logic [POS_W-1:0] POS_LEFT_NEG = 5'h01;
	localparam logic [POS_W-1:0] POS_LEFT_POS2 = 5'h02;
	localparam logic [POS_W-1:0] POS_RIGHT_POS1 = 5'h08;
	localparam logic [POS_W-1:0] POS_RIGHT_NEG = 5'h09;
	localparam logic [POS_W-1:0] POS_RIGHT_POS2 = 5'h0a;

	// Per-bit storage map: home location, alias location, value after reset.
	// Entry 0 is the master enable; all others are held while it is clear.
	localparam logic [IDX_W-1:0] BIT_IDX_A [NUM_BITS] = '{
		IDX_POWER_MGMT_FIVE, IDX_POWER_MGMT_FOUR, IDX_POWER_MGMT_ONE,
		IDX_POWER_MGMT_TWO, IDX_POWER_MGMT_TWO, IDX_MIC_INPUT_ROUTING,
		IDX_MIC_INPUT_ROUTING, IDX_MIC_INPUT_ROUTING, IDX_MIC_INPUT_ROUTING,
		IDX_MIC_INPUT_ROUTING, IDX_MIC_INPUT_ROUTING};
	localparam logic [POS_W-1:0] BIT_POS_A [NUM_BITS] = '{
		POS_MASTER, POS_SYSCLOCK, POS_BIAS, POS_LEFT_PREAMP, POS_RIGHT_PREAMP,
		POS_LEFT_POS1, POS_LEFT_NEG, POS_LEFT_POS2, POS_RIGHT_POS1,
		POS_RIGHT_NEG, POS_RIGHT_POS2};
	localparam logic [IDX_W-1:0] BIT_IDX_B [NUM_BITS] = '{
		IDX_POWER_MGMT_FIVE, IDX_POWER_MGMT_FOUR, IDX_POWER_MGMT_ONE,
		IDX_LEFT_INPUT_VOLUME, IDX_RIGHT_INPUT_VOLUME, IDX_MIC_INPUT_ROUTING,
		IDX_MIC_INPUT_ROUTING, IDX_MIC_INPUT_ROUTING, IDX_MIC_INPUT_ROUTING,
		IDX_MIC_INPUT_ROUTING, IDX_MIC_INPUT_ROUTING};
	localparam logic [POS_W-1:0] BIT_POS_B [NUM_BITS] = '{
		POS_MASTER, POS_SYSCLOCK, POS_BIAS, POS_VOL_PREAMP, POS_VOL_PREAMP,
		POS_LEFT_POS1, POS_LEFT_NEG, POS_LEFT_POS2, POS_RIGHT_POS1,
		POS_RIGHT_NEG, POS_RIGHT_POS2};
	localparam logic [NUM_BITS-1:0] BIT_RESET = 11'h360;
endpackage

// ### ctrl_bit.sv
// One control bit reachable at two register locations, with a hold input.
`timescale 1ns/10ps
module ctrl_bit #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hold,
	input wire logic wr_a,
	input wire logic d_a,
	input wire logic wr_b,
	input wire logic d_b,
	output logic q_ff
);
	// Hold beats any write, so a held bit cannot be changed by software.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q_ff <= RST_VAL;
		end else if (hold) begin
			q_ff <= RST_VAL;
		end else if (wr_a) begin
			q_ff <= d_a;
		end else if (wr_b) begin
			q_ff <= d_b;
		end
	end
endmodule

// ### test_codec_enable_input_select_regs.sv
// Self-checking testbench for the codec enable and input routing registers.
`timescale 1ns/10ps
module test_codec_enable_input_select_regs;
	import codec_regs_pkg::*;
	typedef struct packed {logic rd; logic [31:0] data; logic err;} note_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata;
	logic codec_master_enable, codec_sysclock_enable, analog_bias_enable;
	logic left_preamp_enable, right_preamp_enable;
	logic left_pos1_connect, left_neg_connect, left_pos2_connect;
	logic right_pos1_connect, right_neg_connect, right_pos2_connect;
	logic [15:0] r08, r09, r0b, r0c, r48;
	note_t notes[$];
	note_t mon_note;
	int err_total = 0;
	int n_checks = 0;
	int seed;
	int k;
	logic [31:0] d;
	logic [7:0] map_idx [7] = '{IDX_POWER_MGMT_ONE, IDX_POWER_MGMT_TWO,
		IDX_POWER_MGMT_FOUR, IDX_POWER_MGMT_FIVE, IDX_MIC_INPUT_ROUTING,
		IDX_LEFT_INPUT_VOLUME, IDX_RIGHT_INPUT_VOLUME};
	logic [11:0] bad [4] = '{12'h028, 12'h021, 12'h420, 12'h3fc};
	int pins [6] = '{0, 1, 2, 8, 9, 10};

	always #10 pclk = ~pclk;

	codec_enable_input_select_regs codec_enable_input_select_regs_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.codec_master_enable(codec_master_enable),
		.codec_sysclock_enable(codec_sysclock_enable),
		.analog_bias_enable(analog_bias_enable),
		.left_preamp_enable(left_preamp_enable),
		.right_preamp_enable(right_preamp_enable),
		.left_pos1_connect(left_pos1_connect),
		.left_neg_connect(left_neg_connect),
		.left_pos2_connect(left_pos2_connect),
		.right_pos1_connect(right_pos1_connect),
		.right_neg_connect(right_neg_connect),
		.right_pos2_connect(right_pos2_connect));

	codec_host_model codec_host_model_inst (
		.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata));

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task results;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	function logic [11:0] addr(input logic [7:0] i);
		return {2'b00, i, 2'b00};
	endfunction

	function logic is_map(input logic [11:0] a);
		return a[1:0] == 2'b00 && a[11:10] == 2'b00 && (a[9:2] inside
			{8'h08, 8'h09, 8'h0b, 8'h0c, 8'h48, 8'h50, 8'h51});
	endfunction

	function logic [15:0] exp_rd(input logic [7:0] i);
		case (i)
		IDX_POWER_MGMT_ONE: return r08;
		IDX_POWER_MGMT_TWO: return r09;
		IDX_POWER_MGMT_FOUR: return r0b;
		IDX_POWER_MGMT_FIVE: return r0c;
		IDX_MIC_INPUT_ROUTING: return r48;
		IDX_LEFT_INPUT_VOLUME: return {r09[8], 15'h0};
		IDX_RIGHT_INPUT_VOLUME: return {r09[9], 15'h0};
		default: return 16'h0;
		endcase
	endfunction

	task shadow_reset;
		r08 = 16'h0;
		r09 = 16'h0;
		r0b = 16'h0;
		r0c = 16'h0;
		r48 = 16'h0303;
	endtask

	// Clearing the master enable puts every other bit back to reset.
	task upd(input logic [7:0] i, input logic [31:0] v);
		if (i == IDX_POWER_MGMT_FIVE) begin
			if (v[12] === 1'b0)
				shadow_reset;
			r0c = v[15:0] & 16'h1000;
		end else if (r0c[12]) begin
			case (i)
			IDX_POWER_MGMT_ONE: r08 = v[15:0] & 16'h0020;
			IDX_POWER_MGMT_TWO: r09 = v[15:0] & 16'h0300;
			IDX_POWER_MGMT_FOUR: r0b = v[15:0] & 16'h4000;
			IDX_MIC_INPUT_ROUTING: r48 = v[15:0] & 16'h0707;
			IDX_LEFT_INPUT_VOLUME: r09[8] = v[15];
			IDX_RIGHT_INPUT_VOLUME: r09[9] = v[15];
			default: ;
			endcase
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		logic [31:0] rd;
		logic e;
		notes.push_back('{1'b0, 32'h0, ~is_map(a)});
		codec_host_model_inst.xfer(1'b1, a, v, rd, e);
		if (is_map(a))
			upd(a[9:2], v);
	endtask

	task automatic rdc(input logic [11:0] a);
		logic [31:0] rd;
		logic e;
		notes.push_back('{1'b1, is_map(a) ? {16'h0, exp_rd(a[9:2])} : 32'h0,
			~is_map(a)});
		codec_host_model_inst.xfer(1'b0, a, 32'h0, rd, e);
	endtask

	task read_all;
		foreach (map_idx[j])
			rdc(addr(map_idx[j]));
	endtask

	task chk_outs;
		@(posedge pclk);
		#1;
		check({21'h0, codec_master_enable, codec_sysclock_enable,
			analog_bias_enable, left_preamp_enable, right_preamp_enable,
			left_pos1_connect, left_neg_connect, left_pos2_connect,
			right_pos1_connect, right_neg_connect, right_pos2_connect},
			{21'h0, r0c[12], r0b[14], r08[5], r09[8], r09[9], r48[0], r48[1],
			r48[2], r48[8], r48[9], r48[10]});
	endtask

	// Compares each completed transfer with the oldest note.
	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			mon_note = notes.pop_front();
			check({31'h0, pslverr}, {31'h0, mon_note.err});
			if (mon_note.rd)
				check(prdata, mon_note.data);
		end
	end

	initial begin
		#1000000;
		err_total++;
		results;
	end

	initial begin
		seed = 32'h25f42689;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		shadow_reset;
		chk_outs;
		read_all;
		foreach (map_idx[j])
			if (map_idx[j] != IDX_POWER_MGMT_FIVE)
				wr(addr(map_idx[j]), 32'hffffffff);
		chk_outs;
		read_all;
		// Mid-rail and anti-pop sit elsewhere; power-up here is this order.
		wr(addr(IDX_POWER_MGMT_FIVE), 32'h1000);
		wr(addr(IDX_POWER_MGMT_FOUR), 32'h4000);
		wr(addr(IDX_POWER_MGMT_ONE), 32'h0020);
		chk_outs;
		wr(addr(IDX_LEFT_INPUT_VOLUME), 32'h8000);
		rdc(addr(IDX_POWER_MGMT_TWO));
		wr(addr(IDX_POWER_MGMT_TWO), 32'h0200);
		rdc(addr(IDX_LEFT_INPUT_VOLUME));
		rdc(addr(IDX_RIGHT_INPUT_VOLUME));
		chk_outs;
		foreach (pins[j]) begin
			wr(addr(IDX_MIC_INPUT_ROUTING), 32'h1 << pins[j]);
			chk_outs;
		end
		foreach (bad[j]) begin
			wr(bad[j], 32'hffffffff);
			rdc(bad[j]);
		end
		chk_outs;
		repeat (120) begin
			k = $unsigned($random(seed)) % 7;
			d = $random(seed);
			wr(addr(map_idx[k]), d);
			rdc(addr(map_idx[k]));
			chk_outs;
		end
		// Power-down ends by clearing the master enable last.
		wr(addr(IDX_POWER_MGMT_FIVE), 32'h0);
		chk_outs;
		read_all;
		// Leave bits away from reset so the mid-run reset has work to do.
		wr(addr(IDX_POWER_MGMT_FIVE), 32'h1000);
		wr(addr(IDX_MIC_INPUT_ROUTING), 32'h0404);
		wr(addr(IDX_POWER_MGMT_TWO), 32'h0300);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		shadow_reset;
		chk_outs;
		read_all;
		results;
	end
endmodule
